// >>> core/hpa_pkg.sv
// package for the host pointer address generator
// assumes a single 40 MHz system clock domain
`default_nettype none
package hpa_pkg;
  localparam int ADDR_W = 32;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  // structure kinds presented with each pointer
  typedef enum logic [3:0] {
    HPA_K_CMD_LIST,
    HPA_K_CMD_LINK,
    HPA_K_TX_DESC_ARRAY,
    HPA_K_DUMP_BUF,
    HPA_K_RX_AREA,
    HPA_K_RX_LINK,
    HPA_K_TX_BUF,
    HPA_K_PORT_DUMP,
    HPA_K_DUMP_CNT
  } hpa_kind_t;
  typedef enum logic [1:0] {
    HPA_SEL_CMD,
    HPA_SEL_RX,
    HPA_SEL_NONE
  } hpa_sel_t;
endpackage
`default_nettype wire

// >>> core/hpa_gen.sv
// address generator: base plus offset for shared-memory structures
// assumes command and receive units present one request per cycle
`default_nettype none
// Behaviour
// - based pointers: physical address is full 32-bit base plus offset
// - command base for list, links, descriptor arrays, dump; receive base for receive area and receive links
// - transmit buffers, port dump, dump counters use offset as address directly
// - all 32 offset bits are added, upper half never masked
// - transmit buffers may start at any byte address, odd or even
module hpa_gen (
  input  wire logic                 clk_sys_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 load_cmd_base_in,
  input  wire logic                 load_rx_base_in,
  input  wire logic [31:0]          base_value_in,
  input  wire logic                 units_idle_in,
  input  wire logic                 req_valid_in,
  input  wire hpa_pkg::hpa_kind_t   req_kind_in,
  input  wire logic [31:0]          req_offset_in,
  output logic                      addr_valid_out,
  output logic [31:0]               addr_out,
  output logic [31:0]               cmd_base_out,
  output logic [31:0]               rx_base_out,
  output logic                      load_refused_out
);
  typedef struct packed {
    logic [31:0] cmd_base;
    logic [31:0] rx_base;
    logic        valid;
    logic [31:0] addr;
    logic        refused;
  } hpa_state_t;

  hpa_state_t st;
  hpa_state_t next_st;
  hpa_pkg::hpa_sel_t sel;
  logic [31:0] base_pick;

  always_comb begin
    unique case (req_kind_in)
      hpa_pkg::HPA_K_CMD_LIST,
      hpa_pkg::HPA_K_CMD_LINK,
      hpa_pkg::HPA_K_TX_DESC_ARRAY,
      hpa_pkg::HPA_K_DUMP_BUF:  sel = hpa_pkg::HPA_SEL_CMD;
      hpa_pkg::HPA_K_RX_AREA,
      hpa_pkg::HPA_K_RX_LINK:   sel = hpa_pkg::HPA_SEL_RX;
      default:                  sel = hpa_pkg::HPA_SEL_NONE;
    endcase
  end

  always_comb begin
    unique case (sel)
      hpa_pkg::HPA_SEL_CMD: base_pick = st.cmd_base;
      hpa_pkg::HPA_SEL_RX:  base_pick = st.rx_base;
      default:              base_pick = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.refused = 1'b0;
    // loads outside idle are ignored so a running unit never sees its base move
    if (load_cmd_base_in || load_rx_base_in) begin
      if (units_idle_in) begin
        if (load_cmd_base_in) begin
          next_st.cmd_base = base_value_in;
        end
        if (load_rx_base_in) begin
          next_st.rx_base = base_value_in;
        end
      end else begin
        next_st.refused = 1'b1;
      end
    end
    next_st.valid = req_valid_in;
    // no alignment check: odd offsets pass untouched
    if (req_valid_in) begin
      // sum kept at 32 bits on purpose: the carry out of bit 31 is dropped
      next_st.addr = 32'(base_pick + req_offset_in);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st <= '{cmd_base: hpa_pkg::BASE_RST, rx_base: hpa_pkg::BASE_RST,
              valid: 1'b0, addr: 32'h0000_0000, refused: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign addr_valid_out   = st.valid;
  assign addr_out         = st.addr;
  assign cmd_base_out     = st.cmd_base;
  assign rx_base_out      = st.rx_base;
  assign load_refused_out = st.refused;

  // request qualifiers shared by the address checks below
  sequence req_s;
    req_valid_in && !sys_rst_in;
  endsequence

  sequence cmd_req_s;
    req_s ##0 (sel == hpa_pkg::HPA_SEL_CMD);
  endsequence

  sequence rx_req_s;
    req_s ##0 (sel == hpa_pkg::HPA_SEL_RX);
  endsequence

  sequence direct_req_s;
    req_s ##0 (sel == hpa_pkg::HPA_SEL_NONE);
  endsequence

  sequence cmd_load_s;
    load_cmd_base_in && units_idle_in;
  endsequence

  sequence rx_load_s;
    load_rx_base_in && units_idle_in;
  endsequence

  sequence busy_load_s;
    (load_cmd_base_in || load_rx_base_in) && !units_idle_in;
  endsequence

  based_cmd_sum_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    cmd_req_s |=> addr_out == $past(st.cmd_base) + $past(req_offset_in))
    else $error("command based address wrong");

  based_rx_sum_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    rx_req_s |=> addr_out == $past(st.rx_base) + $past(req_offset_in))
    else $error("receive based address wrong");

  direct_offset_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    direct_req_s |=> addr_out == $past(req_offset_in))
    else $error("direct address not equal to offset");

  cmd_kind_sel_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    req_s |-> (sel == hpa_pkg::HPA_SEL_CMD) ==
      (req_kind_in inside {hpa_pkg::HPA_K_CMD_LIST, hpa_pkg::HPA_K_CMD_LINK,
                           hpa_pkg::HPA_K_TX_DESC_ARRAY, hpa_pkg::HPA_K_DUMP_BUF}))
    else $error("command base not picked for command structure");

  rx_kind_sel_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    req_s |-> (sel == hpa_pkg::HPA_SEL_RX) ==
      (req_kind_in inside {hpa_pkg::HPA_K_RX_AREA, hpa_pkg::HPA_K_RX_LINK}))
    else $error("receive base not picked for receive structure");

  upper_offset_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    cmd_req_s ##0 (req_offset_in[31:16] != 16'h0000) |=>
      addr_out != $past(st.cmd_base) + {16'h0000, $past(req_offset_in[15:0])})
    else $error("upper offset bits masked");

  rx_upper_offset_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    rx_req_s ##0 (req_offset_in[31:16] != 16'h0000) |=>
      addr_out != $past(st.rx_base) + {16'h0000, $past(req_offset_in[15:0])})
    else $error("upper offset bits masked on receive side");

  odd_byte_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    req_s ##0 (req_kind_in == hpa_pkg::HPA_K_TX_BUF) ##0 req_offset_in[0] |=> addr_out[0])
    else $error("odd transmit buffer address lost");

  // a carry out of bit 31 shows as a result below the base
  wrap_carry_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    rx_req_s ##0 (32'(rx_base_out + req_offset_in) < rx_base_out) |=>
      addr_out < $past(rx_base_out))
    else $error("address did not wrap");

  cmd_wrap_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    cmd_req_s ##0 (32'(cmd_base_out + req_offset_in) < cmd_base_out) |=>
      addr_out < $past(cmd_base_out))
    else $error("command address did not wrap");

  valid_follow_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    req_valid_in |=> addr_valid_out ##1 ($past(req_valid_in) == addr_valid_out))
    else $error("address valid not one cycle after request");

  valid_idle_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !req_valid_in |=> !addr_valid_out)
    else $error("address valid without a request");

  addr_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !req_valid_in |=> $stable(addr_out))
    else $error("address moved without a request");

  busy_load_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (load_cmd_base_in && !units_idle_in) |=> $stable(cmd_base_out) && load_refused_out)
    else $error("base loaded while a unit was busy");

  busy_rx_load_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    busy_load_s |=> load_refused_out && $stable(rx_base_out) && $stable(cmd_base_out))
    else $error("receive base loaded while a unit was busy");

  cmd_load_lands_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    cmd_load_s |=> cmd_base_out == $past(base_value_in) && !load_refused_out)
    else $error("command base load while idle lost");

  rx_load_lands_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    rx_load_s |=> rx_base_out == $past(base_value_in) && !load_refused_out)
    else $error("receive base load while idle lost");

  quiet_base_a: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !load_cmd_base_in && !load_rx_base_in |=>
      $stable(cmd_base_out) && $stable(rx_base_out) && !load_refused_out)
    else $error("base or refusal changed without a load");
endmodule
`default_nettype wire

// >>> verif/hpa_host_mem.sv
// host memory stand-in: counts bus-master accesses
// assumes one access per address pulse
`default_nettype none
module hpa_host_mem (
  input  wire logic        clk_sys_in,
  input  wire logic        access_in,
  output logic      [15:0] hits_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial hits_out = 16'h0000;
  always @(posedge clk_sys_in) if (access_in === 1'h1) hits_out <= hits_out + 16'h0001;
endmodule
`default_nettype wire

// >>> verif/host_pointer_address_generator_bench.sv
// bench: loads bases, sends pointer requests, checks addresses
// assumes hpa_gen answers one cycle after each request
`default_nettype none
module host_pointer_address_generator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys_in, sys_rst_in, lc, lr, idle, rv, av, refd;
  hpa_pkg::hpa_kind_t kind, kn;
  logic [31:0]        bv, off, addr, cbo, rbo, cb, rb, r, o;
  logic [15:0]        hits;
  logic [31:0]        q[$];
  int                 err_total, compares, sent;
  logic [31:0]        bases [3] = '{32'h1234_0000, 32'hFFFF_FFF0, 32'h0000_0000};
  hpa_gen dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .load_cmd_base_in(lc),
    .load_rx_base_in(lr), .base_value_in(bv), .units_idle_in(idle), .req_valid_in(rv),
    .req_kind_in(kind), .req_offset_in(off), .addr_valid_out(av), .addr_out(addr),
    .cmd_base_out(cbo), .rx_base_out(rbo), .load_refused_out(refd));
  hpa_host_mem mem_u (.clk_sys_in(clk_sys_in), .access_in(av), .hits_out(hits));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] exp_addr(input hpa_pkg::hpa_kind_t k, input logic [31:0] v);
    if (k <= hpa_pkg::HPA_K_DUMP_BUF) return cb + v;
    if (k <= hpa_pkg::HPA_K_RX_LINK) return rb + v;
    return v;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // software side only loads bases
  task automatic load(input logic c, input logic x, input logic [31:0] v, input logic i);
    @(posedge clk_sys_in);
    {lc, lr, bv, idle} <= {c, x, v, i};
    @(posedge clk_sys_in);
    {lc, lr} <= 2'h0;
    #1;
    chk("refused", {31'h0, refd}, {31'h0, !i});
    if (i && c) cb = v;
    if (i && x) rb = v;
    chk("cmd_base", cbo, cb);
    chk("rx_base", rbo, rb);
  endtask
  initial begin
    clk_sys_in = 1'h0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // negedge: outputs launched on the rising edge have settled
  always @(negedge clk_sys_in) begin
    if (av === 1'h1) chk("addr", addr, (q.size() > 0) ? q.pop_front() : ~addr);
  end
  initial begin
    sys_rst_in = 1'h1;
    {lc, lr, idle, rv} = 4'h0;
    {bv, off, cb, rb} = 128'h0;
    r = 32'hD2BB;
    kind = hpa_pkg::HPA_K_CMD_LIST;
    {err_total, compares, sent} = 96'h0;
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'h0;
    #1;
    chk("reset addr", addr, 32'h0);
    for (int j = 0; j < 3; j++) begin
      load(1'h1, 1'h1, bases[j], 1'h1);
      if (j < 2) load(1'h0, 1'h1, bases[j] ^ 32'h0F0F_0000, 1'h1);
      load(1'h1, 1'h1, bases[j] ^ 32'h5A5A_0000, 1'h0);
      for (int k = 0; k < 24; k++) begin
        @(posedge clk_sys_in);
        r = lfsr(r);
        kn = hpa_pkg::hpa_kind_t'(4'(r % 32'h9));
        o = (j == 0) ? {16'h0000, r[15:0]} : r;
        o[0] = o[0] && (kn > hpa_pkg::HPA_K_RX_LINK);
        kind <= kn;
        off <= o;
        rv <= 1'h1;
        q.push_back(exp_addr(kn, o));
        sent++;
      end
      @(posedge clk_sys_in);
      rv <= 1'h0;
    end
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk("pending", 32'(q.size()), 32'h0);
    chk("host hits", {16'h0, hits}, 32'(sent));
    close_out();
  end
endmodule
`default_nettype wire
